/* File: logic/lam_limit_alert_monitor.sv */
/*
 * Limit alert monitor: per-channel window comparators with release
 * margin, sticky violation flags, alert pin and the register file that
 * holds limits, margins and flags.
 * Assumes conversion results arrive on clk as one-cycle strobes, and
 * register accesses arrive from serial-interface logic on link_clk,
 * one at a time, each answered by reg_done.
 * Both clock domains share the one asynchronous reset.
 */
`timescale 1ns/10ps

module lam_limit_alert_monitor (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        link_clk,
   input  wire logic        reg_req,
   input  wire logic        reg_write,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic             reg_ready,
   output logic             reg_done,
   output logic [15:0]      reg_rdata,
   input  wire logic        conv_valid,
   input  wire logic [3:0]  conv_channel,
   input  wire logic [11:0] conv_result,
   output logic             alert
);

   // limit slot decode: {hit, kind[1:0], pair[3:0]}
   // a loop over the pairs keeps the map in one place; the swapped
   // pair is patched inside the loop rather than special-cased later
   function automatic logic [6:0] limit_slot(input logic [5:0] a);
      logic [5:0] up_a;
      logic [5:0] lo_a;
      logic [5:0] mg_a;
      logic [5:0] tmp;
      logic [6:0] r;
      r = 7'h00;
      for (int i = 0; i < lam_pkg::NUM_PAIRS; i++) begin
         up_a = 6'(lam_pkg::OFS_LIMIT_BASE + lam_pkg::LIMIT_STRIDE * i);
         lo_a = up_a + 6'd1;
         mg_a = up_a + 6'd2;
         if (i == lam_pkg::SWAPPED_PAIR) begin
            tmp  = up_a;
            up_a = lo_a;
            lo_a = tmp;
         end
         if (a == up_a) begin
            r = {1'b1, lam_pkg::SLOT_UPPER, 4'(i)};
         end
         if (a == lo_a) begin
            r = {1'b1, lam_pkg::SLOT_LOWER, 4'(i)};
         end
         if (a == mg_a) begin
            r = {1'b1, lam_pkg::SLOT_MARGIN, 4'(i)};
         end
      end
      return r;
   endfunction

   // widen a 12-bit value, signed for temperature channels
   // two spare bits so result plus margin can never wrap
   function automatic logic signed [13:0] widen(input logic [11:0] v,
                                                input logic sgn);
      return sgn ? {{2{v[11]}}, v} : {2'b00, v};
   endfunction

   // command offset decode, shared by write, clear and read
   function automatic logic is_command(input logic [5:0] a);
      return a == lam_pkg::OFS_COMMAND;
   endfunction

   // link-domain request holding registers
   logic        busy_reg;
   logic        req_tgl_reg;
   logic        write_hold_reg;
   logic [5:0]  addr_hold_reg;
   logic [15:0] wdata_hold_reg;
   logic        ack_s1_reg;
   logic        ack_s2_reg;
   logic        ack_s3_reg;
   logic        ack_edge;

   // core-domain handshake registers
   // fire is a one-cycle strobe, one per accepted request
   logic        req_s1_reg;
   logic        req_s2_reg;
   logic        req_s3_reg;
   logic        ack_tgl_reg;
   logic [15:0] rdata_hold_reg;
   logic        fire;

   // register file and monitor state
   logic [11:0] upper_reg  [lam_pkg::NUM_PAIRS];
   logic [11:0] lower_reg  [lam_pkg::NUM_PAIRS];
   logic [11:0] margin_reg [lam_pkg::NUM_PAIRS];
   logic [15:0] cmd_reg;
   logic [9:0]  flag_hi_reg;
   logic [9:0]  flag_lo_reg;
   logic [9:0]  active_hi_reg;
   logic [9:0]  active_lo_reg;
   logic [9:0]  active_hi_next;
   logic [9:0]  active_lo_next;
   logic [9:0]  set_hi;
   logic [9:0]  set_lo;
   logic        alert_reg;
   logic        clear_all;
   logic        cmd_wr;
   logic [6:0]  slot;
   logic [15:0] volt_flags;
   logic [15:0] temp_flags;
   logic [15:0] read_value;

   // link side: accept one request at a time
   // ready is combinational so a new request may follow done at once
   assign reg_ready = ~busy_reg;
   assign ack_edge  = ack_s2_reg ^ ack_s3_reg;

   // link side: capture request, wait for answer toggle
   // holds and toggle move on one edge; the core reads the holds only
   // after the toggle has crossed, so they are settled by then
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg       <= 1'b0;
         req_tgl_reg    <= 1'b0;
         write_hold_reg <= 1'b0;
         addr_hold_reg  <= 6'h00;
         wdata_hold_reg <= 16'h0000;
         reg_done       <= 1'b0;
         reg_rdata      <= 16'h0000;
      end else begin
         reg_done <= 1'b0;
         if (reg_req && !busy_reg) begin
            // held stable until the answer returns
            busy_reg       <= 1'b1;
            req_tgl_reg    <= ~req_tgl_reg;
            write_hold_reg <= reg_write;
            addr_hold_reg  <= reg_addr;
            wdata_hold_reg <= reg_wdata;
         end else if (ack_edge) begin
            busy_reg  <= 1'b0;
            reg_done  <= 1'b1;
            reg_rdata <= rdata_hold_reg;
         end
      end
   end

   // link side: answer toggle synchroniser
   // third flop only marks the toggle edge for the one-cycle pulse
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
         ack_s3_reg <= 1'b0;
      end else begin
         ack_s1_reg <= ack_tgl_reg;
         ack_s2_reg <= ack_s1_reg;
         ack_s3_reg <= ack_s2_reg;
      end
   end

   // core side: request toggle synchroniser
   // toggles, not levels, so no return-to-zero phase is needed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
      end else begin
         req_s1_reg <= req_tgl_reg;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
      end
   end

   // hold registers are stable here, so reading them across is safe
   assign fire      = req_s2_reg ^ req_s3_reg;
   assign slot      = limit_slot(addr_hold_reg);
   assign cmd_wr    = fire && write_hold_reg && is_command(addr_hold_reg);

   // the clear is a one-cycle action, never a stored level
   assign clear_all = cmd_wr && wdata_hold_reg[lam_pkg::CMD_CLEAR_BIT];

   // core side: perform access, return read data with the toggle
   // read word is latched with the toggle, so it crosses settled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_tgl_reg    <= 1'b0;
         rdata_hold_reg <= 16'h0000;
      end else if (fire) begin
         ack_tgl_reg    <= ~ack_tgl_reg;
         rdata_hold_reg <= read_value;
      end
   end

   // command register; the clear bit is an action and reads zero
   // other bits are kept for software; this block acts on none of them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_reg <= lam_pkg::RST_COMMAND;
      end else if (cmd_wr) begin
         cmd_reg <= wdata_hold_reg;
         cmd_reg[lam_pkg::CMD_CLEAR_BIT] <= 1'b0;
      end
   end

   // limit and margin storage, low 12 bits only
   // the top nibble is never stored, so it cannot read back nonzero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < lam_pkg::NUM_PAIRS; i++) begin
            upper_reg[i]  <= (i < lam_pkg::NUM_VOLT) ?
                             lam_pkg::RST_VOLT_UPPER :
                             lam_pkg::RST_TEMP_UPPER;
            lower_reg[i]  <= (i < lam_pkg::NUM_VOLT) ?
                             lam_pkg::RST_VOLT_LOWER :
                             lam_pkg::RST_TEMP_LOWER;
            margin_reg[i] <= lam_pkg::RST_MARGIN;
         end
      end else if (fire && write_hold_reg && slot[6]) begin
         case (slot[5:4])
            lam_pkg::SLOT_UPPER: begin
               upper_reg[slot[3:0]] <= wdata_hold_reg[11:0];
            end
            lam_pkg::SLOT_LOWER: begin
               lower_reg[slot[3:0]] <= wdata_hold_reg[11:0];
            end
            lam_pkg::SLOT_MARGIN: begin
               margin_reg[slot[3:0]] <= wdata_hold_reg[11:0];
            end
            default: begin
            end
         endcase
      end
   end

   // one comparator per check; averaged temp reuses the temp pair
   // ten checks but nine pairs: limits and margin are shared, not copied
   generate
      for (genvar k = 0; k < lam_pkg::NUM_CHECKS; k++) begin : g_chk
         localparam int  PAIR = (k >= lam_pkg::PAIR_TEMP) ?
                                lam_pkg::PAIR_TEMP : k;
         localparam bit  SGN  = (k >= lam_pkg::PAIR_TEMP);
         logic               hit;
         logic signed [13:0] res;
         logic signed [13:0] up;
         logic signed [13:0] lo;
         logic signed [13:0] n;
         assign hit = conv_valid && conv_channel == 4'(k);
         assign res = widen(conv_result, SGN);
         assign up  = widen(upper_reg[PAIR], SGN);
         assign lo  = widen(lower_reg[PAIR], SGN);
         assign n   = {2'b00, margin_reg[PAIR]};
         assign set_hi[k] = hit && (res > up);
         assign set_lo[k] = hit && (res < lo);
         // release needs the full margin inside the window
         // order matters: violation beats clear, clear beats release
         assign active_hi_next[k] =
            set_hi[k] ? 1'b1 :
            clear_all ? 1'b0 :
            (hit && (res + n <= up)) ? 1'b0 :
            active_hi_reg[k];
         assign active_lo_next[k] =
            set_lo[k] ? 1'b1 :
            clear_all ? 1'b0 :
            (hit && (res >= lo + n)) ? 1'b0 :
            active_lo_reg[k];
      end
   endgenerate

   // alert states per check; a fresh violation beats a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_hi_reg <= 10'h000;
         active_lo_reg <= 10'h000;
      end else begin
         active_hi_reg <= active_hi_next;
         active_lo_reg <= active_lo_next;
      end
   end

   // alert pin from a flop, so it cannot glitch as states settle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= |{active_hi_next, active_lo_next};
      end
   end

   assign alert = alert_reg;

   // sticky flags: set wins over the clear in the same cycle
   // losing an event to a racing clear would hide it from software
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_hi_reg <= 10'h000;
         flag_lo_reg <= 10'h000;
      end else begin
         flag_hi_reg <= (clear_all ? 10'h000 : flag_hi_reg) | set_hi;
         flag_lo_reg <= (clear_all ? 10'h000 : flag_lo_reg) | set_lo;
      end
   end

   // flag register images
   // pure wiring; bits not listed here read zero
   always_comb begin
      volt_flags = 16'h0000;
      for (int i = 0; i < lam_pkg::NUM_VOLT; i++) begin
         volt_flags[2 * i]     = flag_lo_reg[i];
         volt_flags[2 * i + 1] = flag_hi_reg[i];
      end
      temp_flags = 16'h0000;
      temp_flags[lam_pkg::TFLAG_TEMP_LO] = flag_lo_reg[lam_pkg::CH_TEMP];
      temp_flags[lam_pkg::TFLAG_TEMP_HI] = flag_hi_reg[lam_pkg::CH_TEMP];
      temp_flags[lam_pkg::TFLAG_AVG_LO]  =
         flag_lo_reg[lam_pkg::CH_TEMP_AVG];
      temp_flags[lam_pkg::TFLAG_AVG_HI]  =
         flag_hi_reg[lam_pkg::CH_TEMP_AVG];
   end

   // read mux; unused and unmapped offsets read zero
   // only needs to settle by the fire cycle, when it is latched
   always_comb begin
      read_value = 16'h0000;
      if (slot[6]) begin
         case (slot[5:4])
            lam_pkg::SLOT_UPPER: begin
               read_value = {4'h0, upper_reg[slot[3:0]]};
            end
            lam_pkg::SLOT_LOWER: begin
               read_value = {4'h0, lower_reg[slot[3:0]]};
            end
            lam_pkg::SLOT_MARGIN: begin
               read_value = {4'h0, margin_reg[slot[3:0]]};
            end
            default: begin
               read_value = 16'h0000;
            end
         endcase
      end else if (is_command(addr_hold_reg)) begin
         read_value = cmd_reg;
      end else if (addr_hold_reg == lam_pkg::OFS_VOLT_FLAGS) begin
         read_value = volt_flags;
      end else if (addr_hold_reg == lam_pkg::OFS_TEMP_FLAGS) begin
         read_value = temp_flags;
      end
   end

endmodule

/* File: common/lam_pkg.sv */
/*
 * Package of constants for the limit alert monitor: register offsets,
 * field positions, reset values and channel numbering.
 * Assumes a single converter delivering 12-bit results tagged with a
 * 4-bit channel number; the registers are reached through a register
 * port fed by the serial interface logic on the link clock.
 */
package lam_pkg;

   // register port geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int VAL_W  = 12;

   // monitored channels: 8 voltage, direct temperature, averaged temp
   localparam int NUM_VOLT   = 8;
   localparam int NUM_PAIRS  = 9;
   localparam int NUM_CHECKS = 10;
   localparam logic [3:0] CH_TEMP     = 4'h8;
   localparam logic [3:0] CH_TEMP_AVG = 4'h9;
   localparam int PAIR_TEMP = 8;

   // register offsets
   localparam logic [5:0] OFS_COMMAND          = 6'h00;
   localparam logic [5:0] OFS_LIMIT_BASE       = 6'h04;
   localparam int         LIMIT_STRIDE         = 3;
   localparam logic [5:0] OFS_CH1_MARGIN       = 6'h06;
   localparam logic [5:0] OFS_CH2_UPPER        = 6'h07;
   localparam logic [5:0] OFS_CH4_LOWER        = 6'h0D;
   localparam logic [5:0] OFS_TEMP_UPPER       = 6'h1C;
   localparam logic [5:0] OFS_TEMP_LOWER       = 6'h1D;
   localparam logic [5:0] OFS_VOLT_FLAGS       = 6'h1F;
   localparam logic [5:0] OFS_TEMP_FLAGS       = 6'h20;
   // this pair has its upper and lower slots swapped in the map
   localparam int         SWAPPED_PAIR         = 3;

   // limit slot kinds inside one pair
   localparam logic [1:0] SLOT_UPPER  = 2'd0;
   localparam logic [1:0] SLOT_LOWER  = 2'd1;
   localparam logic [1:0] SLOT_MARGIN = 2'd2;

   // command register fields
   localparam int CMD_CLEAR_BIT = 2;

   // temperature flag positions
   localparam int TFLAG_TEMP_LO = 0;
   localparam int TFLAG_TEMP_HI = 1;
   localparam int TFLAG_AVG_LO  = 2;
   localparam int TFLAG_AVG_HI  = 3;

   // reset values
   localparam logic [11:0] RST_VOLT_UPPER = 12'hFFF;
   localparam logic [11:0] RST_VOLT_LOWER = 12'h000;
   localparam logic [11:0] RST_TEMP_UPPER = 12'h7FF;
   localparam logic [11:0] RST_TEMP_LOWER = 12'h800;
   localparam logic [11:0] RST_MARGIN     = 12'h000;
   localparam logic [15:0] RST_COMMAND    = 16'h0000;

endpackage

/* File: verification/lam_limit_alert_monitor_chk.sv */
/* checker for the limit alert monitor ports.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module lam_limit_alert_monitor_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        link_clk,
   input wire logic        reg_req,
   input wire logic        reg_write,
   input wire logic [5:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_ready,
   input wire logic        reg_done,
   input wire logic [15:0] reg_rdata,
   input wire logic        conv_valid,
   input wire logic [3:0]  conv_channel,
   input wire logic [11:0] conv_result,
   input wire logic        alert
);
   logic [5:0] addr_reg;
   logic       rd_reg;
   // pending access kept so its answer can be judged later
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= 6'h00;
         rd_reg   <= 1'b0;
      end else if (reg_req && reg_ready) begin
         addr_reg <= reg_addr;
         rd_reg   <= !reg_write;
      end
   end
   a_done_pulse: assert property (@(posedge link_clk) disable iff (!rst_n)
      reg_done |=> !reg_done) else $error("done longer than one cycle");
   a_busy_taken: assert property (@(posedge link_clk) disable iff (!rst_n)
      reg_req && reg_ready |=> !reg_ready) else $error("not busy after take");
   a_answer_bound: assert property (@(posedge link_clk) disable iff (!rst_n)
      $fell(reg_ready) |-> ##[0:12] reg_done) else $error("no answer");
   a_rdata_holds: assert property (@(posedge link_clk) disable iff (!rst_n)
      !reg_done |-> $stable(reg_rdata)) else $error("read data moved");
   a_limit_top_zero: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      reg_done && rd_reg && addr_reg inside {[6'h04:6'h1E]}
      |-> reg_rdata[15:12] == 4'h0) else $error("limit top bits set");
   a_tflag_top_zero: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      reg_done && rd_reg && addr_reg == 6'h20
      |-> reg_rdata[15:4] == 12'h000) else $error("temp flags high bits");
   a_unmapped_zero: assert property (@(posedge link_clk) disable iff (!rst_n)
      reg_done && rd_reg
      && (addr_reg > 6'h20 || addr_reg inside {[6'h01:6'h03]})
      |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   a_alert_cause: assert property (
      @(posedge clk) disable iff (!rst_n) $rose(alert)
      |-> $past(conv_valid) && $past(conv_channel) <= 4'h9)
      else $error("alert rose without conversion");
   a_ignore_channel: assert property (
      @(posedge clk) disable iff (!rst_n)
      conv_valid && conv_channel > 4'h9 && !alert |=> !alert)
      else $error("bad channel raised alert");
endmodule
bind lam_limit_alert_monitor lam_limit_alert_monitor_chk chk_u (
   .clk, .rst_n, .link_clk, .reg_req, .reg_write, .reg_addr, .reg_wdata,
   .reg_ready, .reg_done, .reg_rdata, .conv_valid, .conv_channel,
   .conv_result, .alert);

/* File: verification/lam_host_model.sv */
/* host bus master model for the register port, on link_clk.
   assumes one access at a time, answered by a done pulse. */
`timescale 1ns/10ps
module lam_host_model (
   input  wire logic        link_clk,
   input  wire logic        reg_ready,
   input  wire logic        reg_done,
   input  wire logic [15:0] reg_rdata,
   output logic             reg_req,
   output logic             reg_write,
   output logic [5:0]       reg_addr,
   output logic [15:0]      reg_wdata
);
   // idle values at time zero
   initial begin
      reg_req   = 1'b0;
      reg_write = 1'b0;
      reg_addr  = 6'h00;
      reg_wdata = 16'h0000;
   end
   // held until taken, then scrambled so stale values cannot pass
   task automatic xfer(input logic wr, input logic [5:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic tout);
      int n;
      @(posedge link_clk);
      reg_req   <= 1'b1;
      reg_write <= wr;
      reg_addr  <= a;
      reg_wdata <= d;
      n = 0;
      do begin
         @(posedge link_clk);
         n++;
      end while (reg_ready !== 1'b1 && n < 20);
      reg_req   <= 1'b0;
      reg_write <= ~wr;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
      n = 0;
      do begin
         @(posedge link_clk);
         n++;
      end while (reg_done !== 1'b1 && n < 14);
      q = reg_rdata;
      tout = (reg_done !== 1'b1);
   endtask
endmodule

/* File: verification/lam_limit_alert_monitor_tb.sv */
/* self-checking bench for the limit alert monitor.
   assumes the host model drives the register port on link_clk. */
`timescale 1ns/10ps
module lam_limit_alert_monitor_tb;
   logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
   logic conv_valid = 1'b0, reg_req, reg_write, reg_ready, reg_done, alert;
   logic [3:0]  conv_channel = 4'h0;
   logic [11:0] conv_result = 12'h000;
   logic [5:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   int err_total = 0, comparisons = 0;
   lam_limit_alert_monitor dut_u (.clk, .rst_n, .link_clk, .reg_req,
      .reg_write, .reg_addr, .reg_wdata, .reg_ready, .reg_done, .reg_rdata,
      .conv_valid, .conv_channel, .conv_result, .alert);
   lam_host_model host_u (.link_clk, .reg_ready, .reg_done, .reg_rdata,
      .reg_req, .reg_write, .reg_addr, .reg_wdata);
   // clocks of unrelated period
   always #4 clk = ~clk;
   always #7.5 link_clk = ~link_clk;
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [5:0] a,
      input logic [15:0] d, input logic [15:0] exp);
      logic [15:0] q;
      logic t;
      host_u.xfer(wr, a, d, q, t);
      chk({15'h0000, t}, 16'h0000);
      if (!wr) chk(q, exp);
   endtask
   // one conversion, alert looked at once its edge has landed
   task automatic cv(input logic [3:0] ch, input logic [11:0] r,
      input logic e);
      @(posedge clk);
      conv_valid   <= 1'b1;
      conv_channel <= ch;
      conv_result  <= r;
      @(posedge clk);
      conv_valid  <= 1'b0;
      conv_result <= ~r;
      @(posedge clk);
      chk({15'h0000, alert}, {15'h0000, e});
   endtask
   logic [5:0]  ra [13] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h0D, 6'h0E, 6'h1C,
      6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h01, 6'h3F};
   logic [15:0] rv [13] = '{16'h0FFF, 16'h0000, 16'h0000, 16'h0FFF,
      16'h0000, 16'h0FFF, 16'h07FF, 16'h0800, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000};
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 13; i++) acc(0, ra[i], 0, rv[i]);
      $display("test reset values done");
      acc(1, 6'h06, 16'hFFFF, 0);
      acc(0, 6'h06, 0, 16'h0FFF);
      acc(1, 6'h0D, 16'hF123, 0);
      acc(0, 6'h0D, 0, 16'h0123);
      acc(1, 6'h1F, 16'hFFFF, 0);
      acc(0, 6'h1F, 0, 16'h0000);
      $display("test register access done");
      acc(1, 6'h05, 16'h0100, 0);
      acc(1, 6'h06, 16'h0008, 0);
      cv(4'h0, 12'h900, 0);
      cv(4'h0, 12'h0FF, 1);
      cv(4'h0, 12'h107, 1);
      cv(4'h0, 12'h108, 0);
      acc(0, 6'h1F, 0, 16'h0001);
      $display("test lower limit done");
      acc(1, 6'h07, 16'h0200, 0);
      acc(1, 6'h09, 16'h0004, 0);
      cv(4'h1, 12'h201, 1);
      cv(4'h1, 12'h1FD, 1);
      cv(4'h1, 12'h1FC, 0);
      acc(1, 6'h19, 16'h0010, 0);
      cv(4'h7, 12'h011, 1);
      cv(4'h7, 12'h010, 0);
      acc(0, 6'h1F, 0, 16'h8009);
      $display("test upper limit done");
      acc(1, 6'h1C, 16'h0050, 0);
      acc(1, 6'h1D, 16'h0FF0, 0);
      cv(4'h8, 12'hFE0, 1);
      cv(4'h8, 12'h000, 0);
      cv(4'h9, 12'h060, 1);
      cv(4'h9, 12'h000, 0);
      cv(4'hA, 12'h000, 0);
      acc(0, 6'h20, 0, 16'h0009);
      $display("test temperature done");
      cv(4'h9, 12'h7FF, 1);
      acc(1, 6'h00, 16'h0004, 0);
      repeat (2) @(posedge clk);
      chk({15'h0000, alert}, 16'h0000);
      acc(0, 6'h1F, 0, 16'h0000);
      acc(0, 6'h20, 0, 16'h0000);
      acc(0, 6'h00, 0, 16'h0000);
      $display("test clear done");
      final_report();
   end
   // watchdog, well beyond the expected run of some 4 us
   initial begin
      #100000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
endmodule
